// [verilog/pmde_pkg.sv]
// Shared constants and carrier types for the bus-master DMA engine
package pmde_pkg;
	// Register byte offsets on the register port
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_BCNT = 8'h08;
	localparam logic [7:0] OFS_ISR  = 8'h0c;
	// Control register field positions
	localparam int CTL_INT_ENA = 0;
	localparam int CTL_FLUSH   = 1;
	localparam int CTL_LRST    = 2;
	localparam int CTL_WRITE   = 3;
	localparam int CTL_DMA_ENA = 4;
	localparam int CTL_TCI_DIS = 5;
	localparam int CTL_DMA_ON  = 6;
	// Interrupt status field positions
	localparam int ISR_INT_PEND = 0;
	localparam int ISR_ERR_PEND = 1;
	localparam int ISR_INT_IRQ  = 2;
	localparam int ISR_TC       = 3;
	localparam int ISR_AD_LOAD  = 4;
	// Counter fields: address bits 31..2, byte count bits 16..2
	localparam int ADDR_LSB = 2;
	localparam int BCNT_MSB = 16;
	localparam int BCNT_W   = 15;
	// Buffer depth in DWORDs (64 bytes)
	localparam int BUF_WORDS = 16;
	// Reset values of all registers
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	// PCI bus commands used by the master
	localparam logic [3:0] CMD_MEM_READ  = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
	// Master request towards the PCI core
	typedef struct packed {
		logic        active;
		logic [3:0]  cmd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} pmde_mst_req_s;
	// Master answer from the PCI core
	typedef struct packed {
		logic        xfer;
		logic        err;
		logic [31:0] rdata;
	} pmde_mst_rsp_s;
endpackage : pmde_pkg

// [verilog/pmde_dma_engine.sv]
// Bus-master DMA engine with 16-DWORD buffer and four DMA registers
//
// Our own choices: the plain strobed port and the placing of the registers.

module pmde_dma_engine #(
	parameter int BURST_MAX = pmde_pkg::BUF_WORDS
) (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	// Host register port (PCI target side)
	input  wire logic [7:0]              reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic [31:0]                  reg_rdata,
	// Local register write port
	input  wire logic [31:0]             loc_reg_wdata,
	input  wire logic                    loc_ctrl_wr,
	input  wire logic                    loc_bcnt_wr,
	input  wire logic                    loc_addr_wr,
	// Register monitors
	output logic [6:0]                   ctrl_mon,
	output logic [31:0]                  addr_mon,
	output logic [16:0]                  bcnt_mon,
	output logic [4:0]                   isr_mon,
	// Local data side
	input  wire logic                    loc_req,
	output logic                         loc_ack_n,
	output logic                         loc_wr_n,
	output logic                         loc_rd_n,
	input  wire logic [31:0]             loc_dat_in,
	output logic [31:0]                  loc_dat_out,
	input  wire logic                    loc_irq_n,
	output logic                         loc_reset,
	// PCI master side
	output logic                         pci_req_n,
	input  wire logic                    pci_gnt_n,
	output pmde_pkg::pmde_mst_req_s      mst_req,
	input  wire pmde_pkg::pmde_mst_rsp_s mst_rsp,
	output logic                         pci_inta_n
);
	localparam int IW = 5; // Index and count width
	localparam int BCNT_W_L = pmde_pkg::BCNT_W; // Byte counter width

	// Refuse depths the index logic cannot serve
	if (BURST_MAX < 1 || BURST_MAX > pmde_pkg::BUF_WORDS) begin : g_chk
		$error("BURST_MAX must lie in 1..16");
	end

	// Engine states, Gray coded along the transfer path
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_WAIT  = 3'b001,
		ST_FILL  = 3'b011,
		ST_BREQ  = 3'b010,
		ST_BURST = 3'b110,
		ST_DRAIN = 3'b111,
		ST_DONE  = 3'b101
	} pmde_state_e;

	pmde_state_e             state_ff, nxt_state;   // Sequencer state
	logic [IW-1:0]           idx_ff, nxt_idx;       // Buffer word index
	logic [IW-1:0]           cnt_ff, nxt_cnt;       // Words this round
	logic [31:0]             buf_mem [BURST_MAX];   // RAM buffer
	logic                    buf_we;                // Buffer write
	logic [31:0]             buf_wd;                // Buffer write data
	logic [29:0]             addr_ff, nxt_addr;     // Address bits 31..2
	logic [BCNT_W_L-1:0]     bcnt_ff, nxt_bcnt;     // Byte count 16..2
	logic                    int_ena_ff, nxt_int_ena;
	logic                    lrst_ff, nxt_lrst;
	logic                    write_ff, nxt_write;
	logic                    dma_ena_ff, nxt_dma_ena;
	logic                    tci_dis_ff, nxt_tci_dis;
	logic                    dma_on_ff, nxt_dma_on; // Transfer active
	logic                    err_ff, nxt_err;       // Error pending
	logic                    tc_ff, nxt_tc;         // Terminal count
	logic                    adl_ff, nxt_adl;       // Address loaded
	logic                    irq_ff;                // Local irq level
	logic [31:0]             rdata_ff, nxt_rdata;
	logic                    ack_n_ff, wr_n_ff, rd_n_ff, req_n_ff;
	logic                    inta_n_ff, lreset_ff;
	logic [31:0]             dout_ff, nxt_dout;
	pmde_pkg::pmde_mst_req_s mst_ff, nxt_mst;

	// Write decode: host and local writes share the same registers
	logic        wr_ctrl, wr_addr, wr_bcnt, flush, loc_addr_hit;
	logic [31:0] wd;
	logic        rd_isr;
	always_comb begin
		wr_ctrl = (reg_wr && reg_addr == pmde_pkg::OFS_CTRL)
			|| loc_ctrl_wr;
		wr_addr = (reg_wr && reg_addr == pmde_pkg::OFS_ADDR)
			|| loc_addr_wr;
		wr_bcnt = (reg_wr && reg_addr == pmde_pkg::OFS_BCNT)
			|| loc_bcnt_wr;
		wd = reg_wr ? reg_wdata : loc_reg_wdata;
		flush = wr_ctrl && wd[pmde_pkg::CTL_FLUSH];
		loc_addr_hit = loc_addr_wr && !reg_wr;
		rd_isr = reg_rd && reg_addr == pmde_pkg::OFS_ISR;
	end

	// Sequencer and counters: next values
	logic last;
	always_comb begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		nxt_cnt = cnt_ff;
		nxt_addr = addr_ff;
		nxt_bcnt = bcnt_ff;
		buf_we = 1'b0;
		buf_wd = loc_dat_in;
		last = (idx_ff == cnt_ff - IW'(1));
		unique case (state_ff)
			ST_IDLE: begin
				if (dma_on_ff) begin
					nxt_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (!dma_on_ff || err_ff) begin
					nxt_state = ST_IDLE;
				end else if (bcnt_ff == '0) begin
					nxt_state = ST_DONE;
				end else if (loc_req) begin
					nxt_idx = '0;
					// Round size capped by buffer depth
					nxt_cnt = (bcnt_ff > BCNT_W_L'(BURST_MAX)) ?
						IW'(BURST_MAX) : bcnt_ff[IW-1:0];
					nxt_state = write_ff ? ST_FILL : ST_BREQ;
				end
			end
			ST_FILL: begin
				// Latch one local word per cycle
				buf_we = 1'b1;
				nxt_idx = idx_ff + IW'(1);
				if (last) begin
					nxt_idx = '0;
					nxt_state = ST_BREQ;
				end
			end
			ST_BREQ: begin
				if (err_ff) begin
					nxt_state = ST_IDLE;
				end else if (!pci_gnt_n) begin
					nxt_state = ST_BURST;
				end
			end
			ST_BURST: begin
				if (mst_rsp.err) begin
					nxt_state = ST_IDLE;
				end else if (mst_rsp.xfer) begin
					buf_we = !write_ff;
					buf_wd = mst_rsp.rdata;
					nxt_addr = addr_ff + 30'h0000_0001;
					nxt_bcnt = bcnt_ff - BCNT_W_L'(1);
					nxt_idx = idx_ff + IW'(1);
					if (last) begin
						nxt_idx = '0;
						if (!write_ff) begin
							nxt_state = ST_DRAIN;
						end else if (nxt_bcnt == '0) begin
							nxt_state = ST_DONE;
						end else begin
							nxt_state = ST_WAIT;
						end
					end
				end
			end
			ST_DRAIN: begin
				// One buffered word per cycle to the local side
				nxt_idx = idx_ff + IW'(1);
				if (last) begin
					nxt_idx = '0;
					nxt_state = (bcnt_ff == '0) ? ST_DONE : ST_WAIT;
				end
			end
			ST_DONE: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		// Register writes override counting
		if (wr_addr) begin
			nxt_addr = wd[31:pmde_pkg::ADDR_LSB];
		end
		if (wr_bcnt) begin
			nxt_bcnt = wd[pmde_pkg::BCNT_MSB:pmde_pkg::ADDR_LSB];
		end
		// Flush invalidates buffer contents
		if (flush) begin
			nxt_idx = '0;
			nxt_state = ST_IDLE;
		end
	end

	// Control and status flags: next values
	always_comb begin
		nxt_int_ena = int_ena_ff;
		nxt_lrst = lrst_ff;
		nxt_write = write_ff;
		nxt_dma_ena = dma_ena_ff;
		nxt_tci_dis = tci_dis_ff;
		if (wr_ctrl) begin
			nxt_int_ena = wd[pmde_pkg::CTL_INT_ENA];
			nxt_lrst = wd[pmde_pkg::CTL_LRST];
			nxt_write = wd[pmde_pkg::CTL_WRITE];
			nxt_dma_ena = wd[pmde_pkg::CTL_DMA_ENA];
			nxt_tci_dis = wd[pmde_pkg::CTL_TCI_DIS];
		end
		// Address loaded: set wins over clear
		nxt_adl = adl_ff;
		if (flush || state_ff == ST_DONE) begin
			nxt_adl = 1'b0;
		end
		if (wr_addr) begin
			nxt_adl = 1'b1;
		end
		// Terminal count: set wins over clear
		nxt_tc = tc_ff;
		if (rd_isr || flush || loc_addr_hit) begin
			nxt_tc = 1'b0;
		end
		if (state_ff == ST_DONE) begin
			nxt_tc = 1'b1;
		end
		// Error pending: raised by aborts, cleared by flush
		nxt_err = err_ff;
		if (flush) begin
			nxt_err = 1'b0;
		end
		if (state_ff == ST_BURST && mst_rsp.err) begin
			nxt_err = 1'b1;
		end
		nxt_dma_on = adl_ff && dma_ena_ff && !err_ff;
	end

	// Outputs and read data: next values
	logic [31:0] ctrl_word, isr_word;
	always_comb begin
		ctrl_word = '0;
		ctrl_word[6:0] = {dma_on_ff, tci_dis_ff, dma_ena_ff, write_ff,
			lrst_ff, 1'b0, int_ena_ff};
		isr_word = '0;
		isr_word[4:0] = {adl_ff, tc_ff, irq_ff, err_ff,
			err_ff || tc_ff || irq_ff};
		nxt_rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				pmde_pkg::OFS_CTRL: nxt_rdata = ctrl_word;
				pmde_pkg::OFS_ADDR: nxt_rdata = {addr_ff, 2'b00};
				pmde_pkg::OFS_BCNT: nxt_rdata = {15'h0000, bcnt_ff, 2'b00};
				pmde_pkg::OFS_ISR:  nxt_rdata = isr_word;
				default:            nxt_rdata = '0;
			endcase
		end
		// Master request follows the burst state
		nxt_mst.active = (nxt_state == ST_BURST);
		nxt_mst.cmd = nxt_write ? pmde_pkg::CMD_MEM_WRITE
			: pmde_pkg::CMD_MEM_READ;
		nxt_mst.addr = {nxt_addr, 2'b00};
		nxt_dout = buf_mem[nxt_idx[IW-2:0]];
		// A word written this cycle is not in the array yet; forward it
		if (buf_we && idx_ff == nxt_idx) begin
			nxt_dout = buf_wd;
		end
		nxt_mst.wdata = nxt_dout;
	end

	// Buffer write port
	always_ff @(posedge clk) begin
		if (buf_we) begin
			buf_mem[idx_ff[IW-2:0]] <= buf_wd;
		end
	end

	// State, registers and registered outputs
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			idx_ff <= '0;
			cnt_ff <= '0;
			addr_ff <= '0;
			bcnt_ff <= '0;
			int_ena_ff <= 1'b0;
			lrst_ff <= 1'b0;
			write_ff <= 1'b0;
			dma_ena_ff <= 1'b0;
			tci_dis_ff <= 1'b0;
			dma_on_ff <= 1'b0;
			err_ff <= 1'b0;
			tc_ff <= 1'b0;
			adl_ff <= 1'b0;
			irq_ff <= 1'b0;
			rdata_ff <= pmde_pkg::REG_RESET;
			ack_n_ff <= 1'b1;
			wr_n_ff <= 1'b1;
			rd_n_ff <= 1'b1;
			req_n_ff <= 1'b1;
			inta_n_ff <= 1'b1;
			lreset_ff <= 1'b1;
			dout_ff <= '0;
			mst_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			cnt_ff <= nxt_cnt;
			addr_ff <= nxt_addr;
			bcnt_ff <= nxt_bcnt;
			int_ena_ff <= nxt_int_ena;
			lrst_ff <= nxt_lrst;
			write_ff <= nxt_write;
			dma_ena_ff <= nxt_dma_ena;
			tci_dis_ff <= nxt_tci_dis;
			dma_on_ff <= nxt_dma_on;
			err_ff <= nxt_err;
			tc_ff <= nxt_tc;
			adl_ff <= nxt_adl;
			irq_ff <= !loc_irq_n;
			rdata_ff <= nxt_rdata;
			ack_n_ff <= !(nxt_state == ST_FILL || nxt_state == ST_DRAIN);
			wr_n_ff <= (nxt_state != ST_DRAIN);
			rd_n_ff <= (nxt_state != ST_FILL);
			req_n_ff <= !(nxt_state == ST_BREQ
				|| nxt_state == ST_BURST);
			inta_n_ff <= !(nxt_int_ena && (nxt_err || irq_ff
				|| (nxt_tc && !nxt_tci_dis)));
			lreset_ff <= nxt_lrst;
			dout_ff <= nxt_dout;
			mst_ff <= nxt_mst;
		end
	end

	// Port connections straight from flip-flops, save the OR that forms isr_mon bit 0
	always_comb begin
		reg_rdata = rdata_ff;
		ctrl_mon = ctrl_word[6:0];
		addr_mon = {addr_ff, 2'b00};
		bcnt_mon = {bcnt_ff, 2'b00};
		isr_mon = isr_word[4:0];
		loc_ack_n = ack_n_ff;
		loc_wr_n = wr_n_ff;
		loc_rd_n = rd_n_ff;
		loc_dat_out = dout_ff;
		loc_reset = lreset_ff;
		pci_req_n = req_n_ff;
		mst_req = mst_ff;
		pci_inta_n = inta_n_ff;
	end
endmodule // pmde_dma_engine

// [verification/pmde_dma_checker.sv]
// Port checker for the bus-master DMA engine
module pmde_dma_checker #(
	parameter int BURST_MAX = 16
) (
	input wire logic                    clk,
	input wire logic                    rstn,
	input wire logic                    reg_wr,
	input wire logic                    loc_ctrl_wr,
	input wire logic                    loc_addr_wr,
	input wire logic [31:0]             loc_reg_wdata,
	input wire logic [6:0]              ctrl_mon,
	input wire logic [31:0]             addr_mon,
	input wire logic [16:0]             bcnt_mon,
	input wire logic [4:0]              isr_mon,
	input wire logic                    loc_ack_n,
	input wire logic                    pci_gnt_n,
	input wire pmde_pkg::pmde_mst_req_s mst_req,
	input wire pmde_pkg::pmde_mst_rsp_s mst_rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [5:0] ack_cnt_ff;  // Cycles the local strobe has been low
	logic [5:0] nxt_ack_cnt; // Next count
	// Count the length of one local fill or drain
	always_comb begin
		nxt_ack_cnt = loc_ack_n ? 6'h00 : ack_cnt_ff + 6'h01;
	end
	always_ff @(posedge clk) begin
		ack_cnt_ff <= rstn ? nxt_ack_cnt : 6'h00;
	end
	// One data phase completed on the bus
	sequence s_xfer;
		mst_req.active && mst_rsp.xfer;
	endsequence
	property p_rd_cmd;
		mst_req.active && !ctrl_mon[3] |-> mst_req.cmd == pmde_pkg::CMD_MEM_READ;
	endproperty
	a_rd_cmd: assert property (p_rd_cmd) else $error("bad read command");
	property p_wr_cmd;
		mst_req.active && ctrl_mon[3] |-> mst_req.cmd == pmde_pkg::CMD_MEM_WRITE;
	endproperty
	a_wr_cmd: assert property (p_wr_cmd) else $error("bad write command");
	property p_gnt;
		$rose(mst_req.active) |-> !$past(pci_gnt_n);
	endproperty
	a_gnt: assert property (p_gnt) else $error("burst without grant");
	property p_ad_set;
		loc_addr_wr |=> isr_mon[4];
	endproperty
	a_ad_set: assert property (p_ad_set) else $error("address flag not set");
	property p_on;
		$rose(ctrl_mon[6]) |-> $past(isr_mon[4]) && $past(ctrl_mon[4])
			&& !$past(isr_mon[1]);
	endproperty
	a_on: assert property (p_on) else $error("active bit without cause");
	property p_err;
		$rose(mst_req.active) |-> !$past(isr_mon[1]);
	endproperty
	a_err: assert property (p_err) else $error("burst while error pending");
	property p_addr;
		s_xfer |=> addr_mon == $past(addr_mon) + 32'h0000_0004;
	endproperty
	a_addr: assert property (p_addr) else $error("address did not step");
	property p_bcnt;
		s_xfer |=> bcnt_mon == $past(bcnt_mon) - 17'h0_0004;
	endproperty
	a_bcnt: assert property (p_bcnt) else $error("count did not step");
	property p_ack;
		ack_cnt_ff <= 6'(BURST_MAX);
	endproperty
	a_ack: assert property (p_ack) else $error("local transfer too long");
	property p_ctl;
		loc_ctrl_wr && !reg_wr |=> ctrl_mon[5:2] == $past(loc_reg_wdata[5:2]);
	endproperty
	a_ctl: assert property (p_ctl) else $error("control not updated");
endmodule // pmde_dma_checker

bind pmde_dma_engine pmde_dma_checker #(.BURST_MAX(BURST_MAX)) u_chk (
	.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .loc_ctrl_wr(loc_ctrl_wr),
	.loc_addr_wr(loc_addr_wr), .loc_reg_wdata(loc_reg_wdata),
	.ctrl_mon(ctrl_mon), .addr_mon(addr_mon), .bcnt_mon(bcnt_mon),
	.isr_mon(isr_mon), .loc_ack_n(loc_ack_n), .pci_gnt_n(pci_gnt_n),
	.mst_req(mst_req), .mst_rsp(mst_rsp)
);

// [verification/pmde_pci_model.sv]
// Arbiter and memory target model facing the master port
module pmde_pci_model (
	input wire logic                    clk,
	input wire logic                    pci_req_n,
	input wire logic                    err_inj,
	input wire pmde_pkg::pmde_mst_req_s mst_req,
	output logic                        pci_gnt_n,
	output pmde_pkg::pmde_mst_rsp_s     mst_rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] log_q[$]; // Words moved on the bus, in order
	initial begin
		pci_gnt_n = 1'b1;
		mst_rsp = '0;
	end
	// Random grant delay, random wait states, read data changes every cycle
	always @(posedge clk) begin
		if (pci_req_n)
			pci_gnt_n <= 1'b1;
		else if ($urandom_range(1) == 1)
			pci_gnt_n <= 1'b0;
		if (mst_rsp.xfer && mst_req.active)
			log_q.push_back(mst_req.cmd == pmde_pkg::CMD_MEM_WRITE ?
				mst_req.wdata : mst_rsp.rdata);
		mst_rsp.xfer <= mst_req.active && !err_inj && $urandom_range(3) != 0;
		mst_rsp.err <= mst_req.active && err_inj;
		mst_rsp.rdata <= $urandom;
	end
endmodule // pmde_pci_model

// [verification/tb.sv]
// Self-checking bench for the bus-master DMA engine
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clk, rstn, reg_wr, reg_rd, loc_req, err_inj;
	logic                    loc_ctrl_wr, loc_bcnt_wr, loc_addr_wr, loc_irq_n;
	logic                    loc_ack_n, loc_wr_n, loc_rd_n, pci_req_n;
	logic                    pci_gnt_n, pci_inta_n, loc_reset;
	logic [7:0]              reg_addr;
	logic [31:0]             reg_wdata, reg_rdata, loc_reg_wdata, addr_mon;
	logic [31:0]             loc_dat_in, loc_dat_out;
	logic [6:0]              ctrl_mon;
	logic [16:0]             bcnt_mon;
	logic [4:0]              isr_mon;
	pmde_pkg::pmde_mst_req_s mst_req;
	pmde_pkg::pmde_mst_rsp_s mst_rsp;
	logic [31:0]             lq[$]; // Words seen on the local data side
	int                      err_total, cmp_count;
	pmde_dma_engine u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .loc_reg_wdata(loc_reg_wdata),
		.loc_ctrl_wr(loc_ctrl_wr), .loc_bcnt_wr(loc_bcnt_wr),
		.loc_addr_wr(loc_addr_wr), .ctrl_mon(ctrl_mon), .addr_mon(addr_mon),
		.bcnt_mon(bcnt_mon), .isr_mon(isr_mon), .loc_req(loc_req),
		.loc_ack_n(loc_ack_n), .loc_wr_n(loc_wr_n), .loc_rd_n(loc_rd_n),
		.loc_dat_in(loc_dat_in), .loc_dat_out(loc_dat_out),
		.loc_irq_n(loc_irq_n), .loc_reset(loc_reset),
		.pci_req_n(pci_req_n),
		.pci_gnt_n(pci_gnt_n), .mst_req(mst_req), .mst_rsp(mst_rsp),
		.pci_inta_n(pci_inta_n));
	pmde_pci_model u_mem (.clk(clk), .pci_req_n(pci_req_n), .err_inj(err_inj),
		.mst_req(mst_req), .pci_gnt_n(pci_gnt_n), .mst_rsp(mst_rsp));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Local peripheral: supplies fresh words, records every word it supplies or receives
	always @(posedge clk) begin
		if (!loc_rd_n) begin
			lq.push_back(loc_dat_in);
			loc_dat_in <= $urandom;
		end
		if (!loc_wr_n)
			lq.push_back(loc_dat_out);
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic host_wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Let an edge pass so a following call never reassigns the strobe
		@(posedge clk);
	endtask
	task automatic host_rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
	task automatic loc_wr(input logic [2:0] s, input logic [31:0] d);
		loc_reg_wdata <= d;
		{loc_addr_wr, loc_bcnt_wr, loc_ctrl_wr} <= s;
		@(posedge clk);
		{loc_addr_wr, loc_bcnt_wr, loc_ctrl_wr} <= 3'b000;
		// Let an edge pass so a following call never reassigns the strobes
		@(posedge clk);
	endtask
	// One whole transfer of n words; control, count, address last
	task automatic run(input logic wr, input logic host, input int n);
		logic [31:0] a;
		logic [31:0] c;
		a = $urandom & 32'hffff_fffc;
		c = wr ? 32'h0000_0019 : 32'h0000_0011;
		// Single-word transfers also mask the completion interrupt
		if (n == 1)
			c = c | 32'h0000_0020;
		lq.delete();
		u_mem.log_q.delete();
		if (host) begin
			host_wr(pmde_pkg::OFS_CTRL, c);
			host_wr(pmde_pkg::OFS_BCNT, 32'(n * 4));
			host_wr(pmde_pkg::OFS_ADDR, a);
		end else begin
			loc_wr(3'b001, c);
			loc_wr(3'b010, 32'(n * 4));
			loc_wr(3'b100, a);
		end
		repeat (10) @(posedge clk);
		chk(isr_mon[4], 1'b1);
		chk(ctrl_mon[6], 1'b1);
		chk(pci_req_n, 1'b1);
		loc_req <= 1'b1;
		for (int t = 0; t < 3000; t++) begin
			@(posedge clk);
			if (isr_mon[3] === 1'b1 && lq.size() >= n)
				break;
		end
		loc_req <= 1'b0;
		@(posedge clk);
		chk(lq.size(), n);
		chk(u_mem.log_q.size(), n);
		for (int k = 0; k < n; k++)
			chk(lq[k], u_mem.log_q[k]);
		chk(addr_mon, a + 32'(n * 4));
		chk(bcnt_mon, '0);
		chk(isr_mon[4], 1'b0);
		chk(pci_inta_n, c[pmde_pkg::CTL_TCI_DIS]);
		host_rd(pmde_pkg::OFS_ISR, c);
		chk(c[pmde_pkg::ISR_TC], 1'b1);
		repeat (2) @(posedge clk);
		chk(isr_mon[3], 1'b0);
		$display("transfer of %0d words done", n);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge clk);
		err_total++;
		report_and_stop();
	end
	initial begin
		logic [31:0] c;
		void'($urandom(32'h6732_7fa5));
		{rstn, reg_wr, reg_rd, loc_req, err_inj} = '0;
		{loc_ctrl_wr, loc_bcnt_wr, loc_addr_wr} = '0;
		{reg_addr, reg_wdata, loc_reg_wdata, loc_dat_in} = '0;
		loc_irq_n = 1'b1;
		err_total = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		// Four registers reset to zero; the unmapped slot reads zero
		for (int i = 0; i <= 16; i += 4) begin
			host_rd(8'(i), c);
			chk(c, pmde_pkg::REG_RESET);
		end
		chk(loc_reset, 1'b0);
		$display("register reset test done");
		// Full and single lengths as reads, one-over as a write, random lengths in both directions
		for (int i = 0; i < 8; i++)
			run(i[0], i[1], i == 0 ? 16 : i == 1 ? 17 : i == 2 ? 1 :
				$urandom_range(40, 1));
		// A bus error stops the engine until a flush
		err_inj <= 1'b1;
		host_wr(pmde_pkg::OFS_CTRL, 32'h0000_0011);
		host_wr(pmde_pkg::OFS_BCNT, 32'h0000_0040);
		host_wr(pmde_pkg::OFS_ADDR, 32'h0000_1000);
		loc_req <= 1'b1;
		repeat (40) @(posedge clk);
		chk(isr_mon[1], 1'b1);
		chk(mst_req.active, 1'b0);
		chk(ctrl_mon[6], 1'b0);
		err_inj <= 1'b0;
		loc_req <= 1'b0;
		host_wr(pmde_pkg::OFS_CTRL, 32'h0000_0017);
		@(posedge clk);
		chk(loc_reset, 1'b1);
		chk(isr_mon[1], 1'b0);
		chk(isr_mon[4], 1'b0);
		$display("error and flush test done");
		report_and_stop();
	end
endmodule // tb
